// ===== trig_cond_pkg.sv
// constants and types for the trigger line conditioning block
package trig_cond_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RISE = 8'h04;
  localparam logic [7:0] OFS_FALL = 8'h08;
  localparam logic [7:0] OFS_DELAY = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // control field positions
  localparam int CTRL_DIR_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_FLIP_OPTO_BIT = 2;
  localparam int CTRL_FLIP_BIDIR_BIT = 3;
  localparam int CTRL_DRIVE_BIT = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // filter and delay ranges, in microseconds
  localparam int GLITCH_W = 13;
  localparam int HOLD_W = 22;
  localparam logic [12:0] GLITCH_MAX_US = 13'(5000);
  localparam logic [21:0] HOLD_MAX_US = 22'(3000000);
  localparam logic [12:0] GLITCH_RESET = 13'h0000;
  localparam logic [21:0] HOLD_RESET = 22'h000000;
  // microsecond tick from the 100 MHz clock
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
  localparam int TICK_W = 7;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);
  // control register layout
  typedef struct packed {
    logic drive;
    logic flip_bidir;
    logic flip_opto;
    logic src_bidir;
    logic dir_out;
  } line_ctrl_t;
  // delay stage states
  typedef enum logic [0:0] {
    DLY_IDLE = 1'b0,
    DLY_WAIT = 1'b1
  } dly_st_t;
  // whole state of the conditioning block
  typedef struct packed {
    line_ctrl_t ctrl;
    logic [12:0] rise;
    logic [12:0] fall;
    logic [21:0] hold;
    logic [1:0] sync_opto;
    logic [1:0] sync_bidir;
    logic in_lvl;
    logic [6:0] tick_cnt;
    logic tick;
    logic lvl;
    logic [12:0] flt_cnt;
    dly_st_t dly_st;
    logic [21:0] dly_cnt;
    logic trig;
    logic bidir_q;
    logic bidir_oe_n;
    logic [31:0] rd_data;
  } cond_state_t;
endpackage : trig_cond_pkg

// ===== trig_cond.sv
// trigger line conditioning: select, invert, edge filters, hold-off delay
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module trig_cond (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [31:0] rd_data_out,
  input wire logic opto_input_line_in,
  input wire logic bidir_line_in,
  output logic bidir_line_out,
  output logic bidir_line_oe_n_out,
  output logic filtered_level_out,
  output logic trig_valid_out
);
  trig_cond_pkg::cond_state_t st;
  trig_cond_pkg::cond_state_t next_st;
  logic rise_seen;
  logic [12:0] width;

  // writes above the documented range saturate rather than wrap
  function automatic logic [12:0] clamp_glitch(input logic [31:0] v);
    clamp_glitch = (v > 32'(trig_cond_pkg::GLITCH_MAX_US)) ? trig_cond_pkg::GLITCH_MAX_US : v[12:0];
  endfunction : clamp_glitch

  function automatic logic [21:0] clamp_hold(input logic [31:0] v);
    clamp_hold = (v > 32'(trig_cond_pkg::HOLD_MAX_US)) ? trig_cond_pkg::HOLD_MAX_US : v[21:0];
  endfunction : clamp_hold

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    rise_seen = 1'b0;
    // register writes
    if (wr_en_in) begin
      case (addr_in)
        trig_cond_pkg::OFS_CTRL: next_st.ctrl = wr_data_in[trig_cond_pkg::CTRL_W-1:0];
        trig_cond_pkg::OFS_RISE: next_st.rise = clamp_glitch(wr_data_in);
        trig_cond_pkg::OFS_FALL: next_st.fall = clamp_glitch(wr_data_in);
        trig_cond_pkg::OFS_DELAY: next_st.hold = clamp_hold(wr_data_in);
        default: begin
        end
      endcase
    end
    // read data stands one cycle only; unmapped reads give zero
    next_st.rd_data = 32'h00000000;
    if (rd_en_in) begin
      case (addr_in)
        trig_cond_pkg::OFS_CTRL: next_st.rd_data = {27'h0000000, st.ctrl};
        trig_cond_pkg::OFS_RISE: next_st.rd_data = {19'h00000, st.rise};
        trig_cond_pkg::OFS_FALL: next_st.rd_data = {19'h00000, st.fall};
        trig_cond_pkg::OFS_DELAY: next_st.rd_data = {10'h000, st.hold};
        trig_cond_pkg::OFS_STATUS: next_st.rd_data = {27'h0000000, st.dly_st == trig_cond_pkg::DLY_WAIT,
                                                       st.lvl, st.in_lvl, st.sync_bidir[1], st.sync_opto[1]};
        default: next_st.rd_data = 32'h00000000;
      endcase
    end
    // pins pass two flops before anything looks at them
    next_st.sync_opto = {st.sync_opto[0], opto_input_line_in};
    next_st.sync_bidir = {st.sync_bidir[0], bidir_line_in};
    // the opto line is only ever sampled, never driven
    next_st.in_lvl = st.ctrl.src_bidir ? (st.sync_bidir[1] ^ st.ctrl.flip_bidir)
                                       : (st.sync_opto[1] ^ st.ctrl.flip_opto);
    // bidir pin drive; oe low means driving
    next_st.bidir_oe_n = ~st.ctrl.dir_out;
    next_st.bidir_q = st.ctrl.drive;
    // microsecond tick
    next_st.tick = 1'b0;
    if (st.tick_cnt == trig_cond_pkg::TICK_LAST) begin
      next_st.tick_cnt = 7'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 7'h01;
    end
    // edge filter: the new level must persist for the edge's width
    width = st.in_lvl ? st.rise : st.fall;
    if (st.in_lvl == st.lvl) begin
      next_st.flt_cnt = 13'h0000;
    end else if ((width == 13'h0000) || (st.flt_cnt > width)) begin // extra tick: first one may land at once
      next_st.lvl = st.in_lvl;
      next_st.flt_cnt = 13'h0000;
      rise_seen = st.in_lvl;
    end else if (st.tick) begin
      next_st.flt_cnt = st.flt_cnt + 13'h0001;
    end
    // hold-off; edges arriving while a delay runs are ignored
    next_st.trig = 1'b0;
    case (st.dly_st)
      trig_cond_pkg::DLY_IDLE: begin
        if (rise_seen) begin
          // one tick more than the hold-off, else tick phase could cut it short
          next_st.dly_cnt = (st.hold == 22'h000000) ? 22'h000000 : st.hold + 22'h000001;
          next_st.dly_st = trig_cond_pkg::DLY_WAIT;
        end
      end
      trig_cond_pkg::DLY_WAIT: begin
        if (st.dly_cnt == 22'h000000) begin
          next_st.trig = 1'b1;
          next_st.dly_st = trig_cond_pkg::DLY_IDLE;
        end else if (st.tick) begin
          next_st.dly_cnt = st.dly_cnt - 22'h000001;
        end
      end
      default: next_st.dly_st = trig_cond_pkg::DLY_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.ctrl <= trig_cond_pkg::CTRL_RESET;
      st.rise <= trig_cond_pkg::GLITCH_RESET;
      st.fall <= trig_cond_pkg::GLITCH_RESET;
      st.hold <= trig_cond_pkg::HOLD_RESET;
      st.bidir_oe_n <= 1'b1;
      st.dly_st <= trig_cond_pkg::DLY_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign rd_data_out = st.rd_data;
  assign bidir_line_out = st.bidir_q;
  assign bidir_line_oe_n_out = st.bidir_oe_n;
  assign filtered_level_out = st.lvl;
  assign trig_valid_out = st.trig;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_bidir_drive_on: assert property (st.ctrl.dir_out |=> !bidir_line_oe_n_out)
    else $error("bidir line not driven in output mode");
  a_bidir_drive_off: assert property (!st.ctrl.dir_out |=> bidir_line_oe_n_out)
    else $error("bidir line driven in input mode");
  a_reset_input: assert property ($rose(rst_n_in) |-> bidir_line_oe_n_out && !st.ctrl.src_bidir)
    else $error("line defaults wrong after reset");
  a_reset_flip: assert property ($rose(rst_n_in) |-> !st.ctrl.flip_opto && !st.ctrl.flip_bidir)
    else $error("polarity flip set after reset");
  a_opto_sampled: assert property (!st.ctrl.src_bidir |=> st.in_lvl == ($past(st.sync_opto[1]) ^ $past(st.ctrl.flip_opto)))
    else $error("opto level not selected or flipped");
  a_glitch_range: assert property (st.rise <= trig_cond_pkg::GLITCH_MAX_US && st.fall <= trig_cond_pkg::GLITCH_MAX_US)
    else $error("filter width out of range");
  a_hold_range: assert property (st.hold <= trig_cond_pkg::HOLD_MAX_US)
    else $error("hold-off out of range");
  a_rise_qualified: assert property ($rose(st.lvl) |-> $past(st.flt_cnt) >= $past(st.rise) && $past(st.in_lvl))
    else $error("rising level passed too early");
  a_fall_qualified: assert property ($fell(st.lvl) |-> $past(st.flt_cnt) >= $past(st.fall) && !$past(st.in_lvl))
    else $error("falling level passed too early");
  a_trig_after_hold: assert property (trig_valid_out |-> $past(st.dly_st) == trig_cond_pkg::DLY_WAIT && $past(st.dly_cnt) == 22'h000000)
    else $error("trigger before hold-off elapsed");
  a_zero_hold: assert property ($rose(st.lvl) && st.hold == 22'h000000 && st.dly_st == trig_cond_pkg::DLY_WAIT |=> trig_valid_out)
    else $error("zero hold-off trigger missing");
  a_tick_period: assert property (st.tick |-> $past(st.tick_cnt) == trig_cond_pkg::TICK_LAST)
    else $error("tick off period");

  c_trigger: cover property (trig_valid_out);
  c_glitch_dropped: cover property (st.flt_cnt != 13'h0000 ##1 st.flt_cnt == 13'h0000 && !$changed(st.lvl));
  c_bidir_source: cover property (st.ctrl.src_bidir && $rose(st.lvl));
  c_bidir_output: cover property (!bidir_line_oe_n_out && bidir_line_out);
endmodule : trig_cond
`default_nettype wire

// ===== sensor_model.sv
// photoelectric sensor model driving the two trigger pins
`timescale 1ns/10ps
`default_nettype none
module sensor_model (
  input wire logic clk_in,
  output logic opto_out,
  output logic bidir_out
);
  // pins idle low; the sensor output stage pulls down
  initial begin
    opto_out = 1'b0;
    bidir_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // set one line and hold it for a number of clocks
  task automatic drive(input bit line, input bit lvl, input int cyc);
    @(posedge clk_in);
    if (line) begin
      bidir_out <= lvl;
    end else begin
      opto_out <= lvl;
    end
    repeat (cyc) @(posedge clk_in);
  endtask : drive
endmodule : sensor_model
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the trigger line conditioning block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk_in, rst_n_in, we, re, opto, s_bi, pin_bi, d_bi, oe_n, flt, trig;
  logic [7:0] addr;
  logic [31:0] wdat, rdat;
  int error_cnt = 0, n_compared = 0, cyc = 0, trig_cnt = 0, tr = 0, t0, n0;
  // the block wins the pin while its enable is low
  assign pin_bi = oe_n ? s_bi : d_bi;
  trig_cond u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wr_data_in(wdat),
    .wr_en_in(we), .rd_en_in(re), .rd_data_out(rdat), .opto_input_line_in(opto), .bidir_line_in(pin_bi),
    .bidir_line_out(d_bi), .bidir_line_oe_n_out(oe_n), .filtered_level_out(flt), .trig_valid_out(trig));
  sensor_model u_sens (.clk_in(sys_clk_in), .opto_out(opto), .bidir_out(s_bi));
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // count trigger pulses and note when the last one came
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (trig === 1'b1) begin
      trig_cnt <= trig_cnt + 1;
      tr <= cyc;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdat <= d;
    we <= 1'b1;
    @(posedge sys_clk_in);
    we <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    addr <= a;
    re <= 1'b1;
    @(posedge sys_clk_in);
    re <= 1'b0;
    #1;
    chk(rdat, exp);
  endtask : rd
  task automatic conclude();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////
  // watchdog, several times the expected run
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial begin
    addr = 8'h00;
    wdat = 32'h0;
    we = 1'b0;
    re = 1'b0;
    rst_n_in = 1'b0;
    repeat (6) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    chk(32'(oe_n), 32'h1);
    rd(trig_cond_pkg::OFS_CTRL, 32'h0);
    rd(trig_cond_pkg::OFS_RISE, 32'h0);
    rd(trig_cond_pkg::OFS_FALL, 32'h0);
    rd(trig_cond_pkg::OFS_DELAY, 32'h0);
    rd(8'h14, 32'h0);
    wr(trig_cond_pkg::OFS_RISE, 32'h1770);
    rd(trig_cond_pkg::OFS_RISE, 32'h1388);
    wr(trig_cond_pkg::OFS_DELAY, 32'h3D0900);
    rd(trig_cond_pkg::OFS_DELAY, 32'h2DC6C0);
    wr(trig_cond_pkg::OFS_RISE, 32'h0);
    wr(trig_cond_pkg::OFS_DELAY, 32'h0);
    // opto is the source after reset; bidir pulses are ignored
    n0 = trig_cnt;
    u_sens.drive(0, 1, 50);
    chk(32'(flt), 32'h1);
    u_sens.drive(0, 0, 50);
    u_sens.drive(1, 1, 50);
    u_sens.drive(1, 0, 50);
    chk(32'(trig_cnt - n0), 32'h1);
    // 3 us rise and fall filters: 2 us excursions are dropped
    wr(trig_cond_pkg::OFS_RISE, 32'h3);
    wr(trig_cond_pkg::OFS_FALL, 32'h3);
    n0 = trig_cnt;
    u_sens.drive(0, 1, 200);
    u_sens.drive(0, 0, 100);
    chk(32'(trig_cnt - n0), 32'h0);
    u_sens.drive(0, 1, 500);
    chk(32'(flt), 32'h1);
    u_sens.drive(0, 0, 200);
    u_sens.drive(0, 1, 200);
    chk(32'(flt), 32'h1);
    u_sens.drive(0, 0, 500);
    chk(32'(flt), 32'h0);
    chk(32'(trig_cnt - n0), 32'h1);
    wr(trig_cond_pkg::OFS_RISE, 32'h0);
    wr(trig_cond_pkg::OFS_FALL, 32'h0);
    // 2 us hold-off; a second rise inside it is not queued
    wr(trig_cond_pkg::OFS_DELAY, 32'h2);
    n0 = trig_cnt;
    t0 = cyc;
    u_sens.drive(0, 1, 50);
    u_sens.drive(0, 0, 50);
    u_sens.drive(0, 1, 50);
    u_sens.drive(0, 0, 300);
    chk(32'(trig_cnt - n0), 32'h1);
    chk(32'(tr - t0 >= 206 && tr - t0 <= 308), 32'h1);
    wr(trig_cond_pkg::OFS_DELAY, 32'h0);
    // flipping a low opto line makes a rise that triggers
    n0 = trig_cnt;
    wr(trig_cond_pkg::OFS_CTRL, 32'h4);
    repeat (10) @(posedge sys_clk_in);
    chk(32'(flt), 32'h1);
    chk(32'(trig_cnt - n0), 32'h1);
    // bidir as driven output, then as input source
    wr(trig_cond_pkg::OFS_CTRL, 32'h13);
    repeat (10) @(posedge sys_clk_in);
    chk(32'(oe_n), 32'h0);
    chk(32'(d_bi), 32'h1);
    chk(32'(flt), 32'h1);
    wr(trig_cond_pkg::OFS_CTRL, 32'h2);
    repeat (10) @(posedge sys_clk_in);
    chk(32'(oe_n), 32'h1);
    chk(32'(flt), 32'h0);
    n0 = trig_cnt;
    u_sens.drive(1, 1, 50);
    u_sens.drive(1, 0, 50);
    chk(32'(trig_cnt - n0), 32'h1);
    wr(trig_cond_pkg::OFS_CTRL, 32'hA);
    repeat (10) @(posedge sys_clk_in);
    chk(32'(flt), 32'h1);
    rd(trig_cond_pkg::OFS_CTRL, 32'hA);
    // status: pins low, flipped level and filtered level high, no delay running
    rd(trig_cond_pkg::OFS_STATUS, 32'hC);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
